// *** shared/dcrb_pkg.sv ***
// dcrb_pkg: register map, field positions, reset values and timing of the config bank
// assumes: byte-wide registers at indices 0..3, 7-bit serial bus addressing
package dcrb_pkg;

	// ---------------------------------------------------------------
	// register indices
	// ---------------------------------------------------------------
	localparam logic [7:0] DCRB_LINK_CONFIG_ONE = 8'h00;
	localparam logic [7:0] DCRB_BUS_ADDRESS_SELECT = 8'h01;
	localparam logic [7:0] DCRB_OUTPUT_FEATURES = 8'h02;
	localparam logic [7:0] DCRB_EQ_SPREAD_FEATURES = 8'h03;
	localparam int DCRB_NUM_REGS = 4;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] DCRB_RST_LINK_CONFIG_ONE = 8'h00;
	localparam logic [7:0] DCRB_RST_BUS_ADDRESS_SELECT = 8'h70;
	localparam logic [7:0] DCRB_RST_OUTPUT_FEATURES = 8'h00;
	localparam logic [7:0] DCRB_RST_EQ_SPREAD_FEATURES = 8'h00;

	// ---------------------------------------------------------------
	// writable-bit masks; reserved bits stay zero
	// ---------------------------------------------------------------
	localparam logic [7:0] DCRB_MASK_LINK_CONFIG_ONE = 8'hcf;
	localparam logic [7:0] DCRB_MASK_BUS_ADDRESS_SELECT = 8'hff;
	localparam logic [7:0] DCRB_MASK_OUTPUT_FEATURES = 8'hcf;
	localparam logic [7:0] DCRB_MASK_EQ_SPREAD_FEATURES = 8'hf7;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int DCRB_LOW_FREQ_BIT = 7;
	localparam int DCRB_LANE_ORDER_BIT = 6;
	localparam int DCRB_MODE_HI = 3;
	localparam int DCRB_MODE_LO = 2;
	localparam int DCRB_SLEEP_BIT = 1;
	localparam int DCRB_REG_CTRL_BIT = 0;
	localparam int DCRB_ADDR_SRC_BIT = 7;
	localparam int DCRB_OUT_EN_BIT = 7;
	localparam int DCRB_IDLE_SEL_BIT = 6;
	localparam int DCRB_SWING_BIT = 3;
	localparam int DCRB_OSC_HI = 2;
	localparam int DCRB_EQUALIZER_GAIN_HI = 7;
	localparam int DCRB_EQUALIZER_GAIN_LO = 5;
	localparam int DCRB_EQ_ON_BIT = 4;
	localparam int DCRB_SPREAD_HI = 2;

	// ---------------------------------------------------------------
	// valid device addresses and oscillator codes
	// ---------------------------------------------------------------
	localparam logic [6:0] DCRB_ADDR_A = 7'h71;
	localparam logic [6:0] DCRB_ADDR_B = 7'h72;
	localparam logic [6:0] DCRB_ADDR_C = 7'h73;
	localparam logic [6:0] DCRB_ADDR_D = 7'h76;
	localparam logic [2:0] DCRB_OSC_OFF = 3'h0;
	localparam logic [2:0] DCRB_OSC_RSVD = 3'h1;

	// ---------------------------------------------------------------
	// timing: core clock period and synchroniser stage count
	// ---------------------------------------------------------------
	localparam int DCRB_CLK_PERIOD_PS = 4000;
	localparam int DCRB_SYNC_STAGES = 2;

	// mode codes of the link
	typedef enum logic [1:0] {
		DCRB_MODE_NORMAL = 2'b00,
		DCRB_MODE_FILTER = 2'b01,
		DCRB_MODE_COMPAT_A = 2'b10,
		DCRB_MODE_COMPAT_B = 2'b11
	} dcrb_mode_t;

	function automatic logic dcrb_addr_valid(input logic [6:0] a);
		return (a == DCRB_ADDR_A) || (a == DCRB_ADDR_B) ||
			(a == DCRB_ADDR_C) || (a == DCRB_ADDR_D);
	endfunction

endpackage

// *** shared/dcrb_wr_if.sv ***
// dcrb_wr_if: write/read requests from the bus engine to the register store
// assumes: all signals on the bus clock domain
`timescale 1ns/1ps
`default_nettype none
interface dcrb_wr_if;
	logic wr_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport engine (output wr_stb, output addr, output wdata, input rdata);
	modport store (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** logic/dcrb_bus_slave.sv ***
// dcrb_bus_slave: serial control bus slave engine, clocked by the bus clock
// assumes: scl_in is the link clock; sda sampled on rising scl, driven after falling scl
`timescale 1ns/1ps
`default_nettype none
module dcrb_bus_slave (
	input wire logic scl_in, // bus clock
	input wire logic rst_n_in, // synchronous reset, scl domain
	input wire logic sda_in, // data line level
	input wire logic [6:0] my_addr_in, // active device address
	output logic sda_oe_out, // pull data line low
	dcrb_wr_if.engine rq // register access
);
	import dcrb_pkg::*;

	typedef enum logic [2:0] {
		DCRB_ST_IDLE = 3'b000,
		DCRB_ST_DEV = 3'b001,
		DCRB_ST_REG = 3'b010,
		DCRB_ST_WDAT = 3'b011,
		DCRB_ST_RDAT = 3'b100
	} dcrb_bst_t;

	dcrb_bst_t state;
	logic [7:0] shift;
	logic [3:0] bitcnt;
	logic [7:0] ptr;
	logic start_tog, stop_tog, start_seen, stop_seen;
	logic start_ack, stop_ack;
	logic [7:0] rd_shift;

	// ---------------------------------------------------------------
	// start and stop flagged by data edges while clock high
	// ---------------------------------------------------------------
	// async clear: the data line has no edges while reset is held
	always_ff @(negedge sda_in or negedge rst_n_in) begin
		if (!rst_n_in)
			start_tog <= 1'b0;
		else if (scl_in)
			start_tog <= ~start_tog;
	end
	always_ff @(posedge sda_in or negedge rst_n_in) begin
		if (!rst_n_in)
			stop_tog <= 1'b0;
		else if (scl_in)
			stop_tog <= ~stop_tog;
	end
	assign start_seen = start_tog ^ start_ack;
	assign stop_seen = stop_tog ^ stop_ack;

	// ---------------------------------------------------------------
	// byte engine on rising clock
	// ---------------------------------------------------------------
	always_ff @(posedge scl_in) begin
		rq.wr_stb <= 1'b0;
		// step on only after the store has taken this byte
		if (rq.wr_stb)
			ptr <= ptr + 8'h01;
		if (!rst_n_in) begin
			state <= DCRB_ST_IDLE;
			bitcnt <= 4'h0;
			ptr <= 8'h00;
			shift <= 8'h00;
			start_ack <= start_tog;
			stop_ack <= stop_tog;
		end else if (start_seen) begin
			start_ack <= start_tog;
			stop_ack <= stop_tog;
			state <= DCRB_ST_DEV;
			shift <= {7'h00, sda_in};
			bitcnt <= 4'h1;
		end else if (stop_seen) begin
			stop_ack <= stop_tog;
			state <= DCRB_ST_IDLE;
		end else if (state != DCRB_ST_IDLE) begin
			if (bitcnt == 4'h8) begin
				bitcnt <= 4'h0;
				unique case (state)
				DCRB_ST_DEV: begin
					if (shift[7:1] != my_addr_in)
						state <= DCRB_ST_IDLE;
					else if (shift[0])
						state <= DCRB_ST_RDAT;
					else
						state <= DCRB_ST_REG;
				end
				DCRB_ST_REG: begin
					ptr <= shift;
					state <= DCRB_ST_WDAT;
				end
				DCRB_ST_WDAT: begin
					rq.wr_stb <= 1'b1;
				end
				DCRB_ST_RDAT: begin
					// master nack ends the read
					if (sda_in)
						state <= DCRB_ST_IDLE;
					else
						ptr <= ptr + 8'h01;
				end
				default: state <= DCRB_ST_IDLE;
				endcase
			end else begin
				shift <= {shift[6:0], sda_in};
				bitcnt <= bitcnt + 4'h1;
			end
		end
	end

	assign rq.addr = ptr;
	assign rq.wdata = shift;

	// ---------------------------------------------------------------
	// data drive on falling clock
	// ---------------------------------------------------------------
	always_ff @(negedge scl_in) begin
		if (!rst_n_in) begin
			sda_oe_out <= 1'b0;
			rd_shift <= 8'h00;
		end else begin
			sda_oe_out <= 1'b0;
			if (bitcnt == 4'h8 && state inside {DCRB_ST_DEV, DCRB_ST_REG, DCRB_ST_WDAT}) begin
				if (state != DCRB_ST_DEV || shift[7:1] == my_addr_in)
					sda_oe_out <= 1'b1;
			end else if (state == DCRB_ST_RDAT && bitcnt != 4'h8) begin
				if (bitcnt == 4'h0)
					rd_shift <= {rq.rdata[6:0], 1'b0};
				else
					rd_shift <= {rd_shift[6:0], 1'b0};
				sda_oe_out <= (bitcnt == 4'h0) ? ~rq.rdata[7] : ~rd_shift[7];
			end
		end
	end

endmodule // dcrb_bus_slave
`default_nettype wire

// *** logic/dcrb_reg_store.sv ***
// dcrb_reg_store: the four configuration registers, written from the bus clock domain
// assumes: writes arrive as one-cycle strobes on scl; power-down keeps the bank
`timescale 1ns/1ps
`default_nettype none
module dcrb_reg_store (
	input wire logic scl_in, // bus clock
	input wire logic rst_n_in, // synchronous reset
	dcrb_wr_if.store rq, // register access
	output logic [31:0] regs_out // all four bytes, index 0 lowest
);
	import dcrb_pkg::*;

	logic [7:0] bank [DCRB_NUM_REGS];

	function automatic logic [7:0] wmask(input logic [7:0] a);
		unique case (a)
		DCRB_LINK_CONFIG_ONE: return DCRB_MASK_LINK_CONFIG_ONE;
		DCRB_BUS_ADDRESS_SELECT: return DCRB_MASK_BUS_ADDRESS_SELECT;
		DCRB_OUTPUT_FEATURES: return DCRB_MASK_OUTPUT_FEATURES;
		DCRB_EQ_SPREAD_FEATURES: return DCRB_MASK_EQ_SPREAD_FEATURES;
		default: return 8'h00;
		endcase
	endfunction

	always_ff @(posedge scl_in) begin
		if (!rst_n_in) begin
			bank[0] <= DCRB_RST_LINK_CONFIG_ONE;
			bank[1] <= DCRB_RST_BUS_ADDRESS_SELECT;
			bank[2] <= DCRB_RST_OUTPUT_FEATURES;
			bank[3] <= DCRB_RST_EQ_SPREAD_FEATURES;
		end else if (rq.wr_stb && rq.addr < 8'(DCRB_NUM_REGS)) begin
			// reserved bits masked to zero
			bank[rq.addr[1:0]] <= rq.wdata & wmask(rq.addr);
		end
	end

	// read returns last value written or reset value
	assign rq.rdata = (rq.addr < 8'(DCRB_NUM_REGS)) ? bank[rq.addr[1:0]] : 8'h00;
	assign regs_out = {bank[3], bank[2], bank[1], bank[0]};

endmodule // dcrb_reg_store
`default_nettype wire

// *** logic/dcrb_top.sv ***
// dcrb_top: configuration register bank of the serial-to-parallel converter
// assumes: bus clock scl_in is the link domain; core logic on clock_in (250 MHz)
//
// How it works
// - register 0 bit 7 set picks 5-20 MHz range, clear picks 20-65 MHz
// - register 0 bit 6 picks lsb or msb colour bits on fourth lane
// - register 0 bits 3:2 pick normal, filtered or two compatible modes
// - register 0 bit 1 puts device to sleep, registers kept
// - register 0 bit 0 picks register over pin configuration, address excepted
// - register 1 bit 7 picks strap or register address source
// - register 1 bits 6:0 hold address; only 71,72,73,76 valid
// - register 2 bit 3 picks 400 mV swing, clear gives 250 mV
// - register 2 bits 2:0 pick fallback oscillator; 000 off, 001 reserved
// - register 3 bits 7:5 set equalizer gain in eight steps
// - register 3 bit 4 enables the equalizer; gain applies only then
// - high range spread codes 1-4 at clock/2168, 5-7 at clock/1300
// - low range spread codes 1-4 at clock/625, 5-7 at clock/385
// - register 0 resets to zero; host writes 01h for register control
// - lost stream gives oscillator clock if enable, idle select, osc code above 001
// - device acks address and write bytes; master nacks last read byte
`timescale 1ns/1ps
`default_nettype none
module dcrb_top (
	input wire logic clock_in, // core clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic scl_in, // serial bus clock
	input wire logic scl_rst_n_in, // reset in bus clock domain
	input wire logic sda_in, // serial bus data level
	output logic sda_oe_out, // pull data line low
	input wire logic [6:0] bus_address_strap_in, // address from strap resistor
	input wire logic pin_low_freq_in, // range pin
	input wire logic pin_lane_order_in, // lane order pin
	input wire logic [1:0] pin_mode_in, // mode pins
	input wire logic pin_out_en_in, // output enable pin
	input wire logic pin_idle_sel_in, // idle state select pin
	input wire logic pin_swing_in, // swing pin
	input wire logic [2:0] pin_spread_in, // spread spectrum pins
	input wire logic stream_lost_in, // serial stream lost
	output logic low_freq_range_select_out, // 1: 5-20 MHz range
	output logic lane_bit_order_select_out, // 1: msb on fourth lane
	output logic [1:0] link_mode_out, // link mode code
	output logic sleep_out, // sleep state
	output logic [6:0] bus_device_address_out, // active slave address
	output logic output_drive_enable_out, // output enable
	output logic output_idle_state_select_out, // idle state select
	output logic swing_level_select_out, // 1: high swing
	output logic [2:0] fallback_osc_freq_select_out, // oscillator code
	output logic [2:0] equalizer_gain_out, // equalizer gain, zero when off
	output logic equalizer_on_out, // equalizer enable
	output logic [2:0] spread_spectrum_setting_out, // spread code
	output logic spread_slow_mod_out, // 1: faster modulation divider set
	output logic fallback_clock_on_out // oscillator drives lane clock
);
	import dcrb_pkg::*;

	// ---------------------------------------------------------------
	// bus domain: engine and store
	// ---------------------------------------------------------------
	dcrb_wr_if rq ();
	logic [31:0] regs_scl;
	logic [6:0] addr_scl;
	logic [6:0] strap_q1, strap_q2;

	always_ff @(posedge scl_in) begin
		strap_q1 <= bus_address_strap_in;
		strap_q2 <= strap_q1;
	end

	// address source select; invalid programmed address falls back to strap
	always_ff @(posedge scl_in) begin
		if (!scl_rst_n_in)
			addr_scl <= DCRB_ADDR_D;
		else if (regs_scl[8 + DCRB_ADDR_SRC_BIT] && dcrb_addr_valid(regs_scl[14:8]))
			addr_scl <= regs_scl[14:8];
		else
			addr_scl <= strap_q2;
	end

	dcrb_bus_slave u_slave (
		.scl_in(scl_in),
		.rst_n_in(scl_rst_n_in),
		.sda_in(sda_in),
		.my_addr_in(addr_scl),
		.sda_oe_out(sda_oe_out),
		.rq(rq)
	);

	dcrb_reg_store u_store (
		.scl_in(scl_in),
		.rst_n_in(scl_rst_n_in),
		.rq(rq),
		.regs_out(regs_scl)
	);

	// ---------------------------------------------------------------
	// crossing: one toggle per write; the bank then stays still a byte time
	// ---------------------------------------------------------------
	logic req_tog;
	logic req_q1, req_q2, req_q3;
	logic [31:0] regs;

	// toggled on the edge that lands the write: no later bus clock needed
	always_ff @(posedge scl_in) begin
		if (!scl_rst_n_in)
			req_tog <= 1'b0;
		else if (rq.wr_stb)
			req_tog <= ~req_tog;
	end

	always_ff @(posedge clock_in) begin
		req_q1 <= req_tog;
		req_q2 <= req_q1;
		if (!rst_n_in) begin
			req_q3 <= 1'b0;
			regs <= 32'h0000_7000;
		end else begin
			req_q3 <= req_q2;
			if (req_q2 != req_q3)
				regs <= regs_scl;
		end
	end

	// ---------------------------------------------------------------
	// core domain: pin synchronisers
	// ---------------------------------------------------------------
	logic [12:0] pins_q1, pins_q2;
	logic lost_q1, lost_q2;
	logic [6:0] strap_c1, strap_c2;
	always_ff @(posedge clock_in) begin
		strap_c1 <= bus_address_strap_in;
		strap_c2 <= strap_c1;
		pins_q1 <= {pin_low_freq_in, pin_lane_order_in, pin_mode_in, pin_out_en_in,
			pin_idle_sel_in, pin_swing_in, pin_spread_in, 3'h0};
		pins_q2 <= pins_q1;
		lost_q1 <= stream_lost_in;
		lost_q2 <= lost_q1;
	end

	// ---------------------------------------------------------------
	// core domain: effective configuration
	// ---------------------------------------------------------------
	logic reg_ctl;
	logic [7:0] r0, r1, r2, r3;
	assign r0 = regs[7:0];
	assign r1 = regs[15:8];
	assign r2 = regs[23:16];
	assign r3 = regs[31:24];
	assign reg_ctl = r0[DCRB_REG_CTRL_BIT];

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			low_freq_range_select_out <= 1'b0;
			lane_bit_order_select_out <= 1'b0;
			link_mode_out <= DCRB_MODE_NORMAL;
			sleep_out <= 1'b0;
			output_drive_enable_out <= 1'b0;
			output_idle_state_select_out <= 1'b0;
			swing_level_select_out <= 1'b0;
			spread_spectrum_setting_out <= 3'h0;
		end else if (reg_ctl) begin
			low_freq_range_select_out <= r0[DCRB_LOW_FREQ_BIT];
			lane_bit_order_select_out <= r0[DCRB_LANE_ORDER_BIT];
			link_mode_out <= r0[DCRB_MODE_HI:DCRB_MODE_LO];
			sleep_out <= r0[DCRB_SLEEP_BIT];
			output_drive_enable_out <= r2[DCRB_OUT_EN_BIT];
			output_idle_state_select_out <= r2[DCRB_IDLE_SEL_BIT];
			swing_level_select_out <= r2[DCRB_SWING_BIT];
			spread_spectrum_setting_out <= r3[DCRB_SPREAD_HI:0];
		end else begin
			low_freq_range_select_out <= pins_q2[12];
			lane_bit_order_select_out <= pins_q2[11];
			link_mode_out <= pins_q2[10:9];
			sleep_out <= r0[DCRB_SLEEP_BIT];
			output_drive_enable_out <= pins_q2[8];
			output_idle_state_select_out <= pins_q2[7];
			swing_level_select_out <= pins_q2[6];
			spread_spectrum_setting_out <= pins_q2[5:3];
		end
	end

	// oscillator, equalizer and spread selection
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			fallback_osc_freq_select_out <= DCRB_OSC_OFF;
			equalizer_gain_out <= 3'h0;
			equalizer_on_out <= 1'b0;
			spread_slow_mod_out <= 1'b0;
			fallback_clock_on_out <= 1'b0;
			bus_device_address_out <= DCRB_ADDR_D;
		end else begin
			// reserved code treated as off
			fallback_osc_freq_select_out <= (r2[DCRB_OSC_HI:0] == DCRB_OSC_RSVD) ?
				DCRB_OSC_OFF : r2[DCRB_OSC_HI:0];
			equalizer_on_out <= r3[DCRB_EQ_ON_BIT];
			equalizer_gain_out <= r3[DCRB_EQ_ON_BIT] ?
				r3[DCRB_EQUALIZER_GAIN_HI:DCRB_EQUALIZER_GAIN_LO] : 3'h0;
			// codes 5-7 use the shorter modulation divider in either range
			spread_slow_mod_out <= (spread_spectrum_setting_out > 3'h4);
			fallback_clock_on_out <= lost_q2 && output_drive_enable_out &&
				output_idle_state_select_out &&
				(fallback_osc_freq_select_out != DCRB_OSC_OFF);
			bus_device_address_out <= (r1[DCRB_ADDR_SRC_BIT] && dcrb_addr_valid(r1[6:0])) ?
				r1[6:0] : strap_c2;
		end
	end

endmodule // dcrb_top
`default_nettype wire

// *** verif/dcrb_chk.sv ***
// dcrb_chk: concurrent checks on the config bank ports
// assumes: bound into dcrb_top; core outputs registered on clock_in
`timescale 1ns/1ps
`default_nettype none
module dcrb_chk (
	input wire logic clock_in, // core clock
	input wire logic rst_n_in, // core reset
	input wire logic scl_in, // bus clock
	input wire logic scl_rst_n_in, // bus reset
	input wire logic sda_oe_out, // data pull
	input wire logic stream_lost_in, // stream lost
	input wire logic [1:0] link_mode_out, // mode
	input wire logic sleep_out, // sleep
	input wire logic [6:0] bus_device_address_out, // address
	input wire logic output_drive_enable_out, // enable
	input wire logic output_idle_state_select_out, // idle select
	input wire logic [2:0] fallback_osc_freq_select_out, // osc code
	input wire logic [2:0] equalizer_gain_out, // gain
	input wire logic equalizer_on_out, // eq on
	input wire logic [2:0] spread_spectrum_setting_out, // spread code
	input wire logic spread_slow_mod_out, // fast divider set
	input wire logic fallback_clock_on_out // fallback clock
);
	// --------
	// checks
	// --------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	a_reset_defaults: assert property (
		$rose(rst_n_in) |-> link_mode_out == 2'b00 && !sleep_out && !equalizer_on_out
	) else $error("config not cleared by reset");
	a_addr_valid: assert property (
		bus_device_address_out inside {7'h71, 7'h72, 7'h73, 7'h76}
	) else $error("reserved device address in use");
	a_gain_zero_off: assert property (
		!equalizer_on_out [*2] |-> equalizer_gain_out == 3'h0
	) else $error("gain applied while equalizer off");
	a_slow_mod_set: assert property (
		(spread_spectrum_setting_out >= 3'h5) [*2] |-> spread_slow_mod_out
	) else $error("fast modulation divider not flagged");
	a_slow_mod_clear: assert property (
		(spread_spectrum_setting_out < 3'h5) [*2] |-> !spread_slow_mod_out
	) else $error("fast modulation divider flagged wrongly");
	a_osc_off_quiet: assert property (
		(fallback_osc_freq_select_out <= 3'h1) [*3] |-> !fallback_clock_on_out
	) else $error("fallback clock with oscillator off");
	a_drive_off_quiet: assert property (
		(!output_drive_enable_out || !output_idle_state_select_out) [*3] |-> !fallback_clock_on_out
	) else $error("fallback clock without enable and idle select");
	a_stream_ok_quiet: assert property (
		!stream_lost_in [*8] |-> !fallback_clock_on_out
	) else $error("fallback clock while stream present");
	a_fallback_runs: assert property (
		(stream_lost_in && output_drive_enable_out && output_idle_state_select_out &&
			fallback_osc_freq_select_out > 3'h1) [*8] |-> fallback_clock_on_out
	) else $error("fallback clock missing");
	a_sda_steady: assert property (
		disable iff (!scl_rst_n_in) scl_in && $past(scl_in) |-> $stable(sda_oe_out)
	) else $error("data line moved while bus clock high");
	c_fallback: cover property (fallback_clock_on_out);
	c_sleep: cover property (sleep_out);
	c_slow_mod: cover property (spread_slow_mod_out && equalizer_on_out);
endmodule // dcrb_chk
bind dcrb_top dcrb_chk i_chk (.clock_in(clock_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
	.scl_rst_n_in(scl_rst_n_in), .sda_oe_out(sda_oe_out), .stream_lost_in(stream_lost_in),
	.link_mode_out(link_mode_out), .sleep_out(sleep_out),
	.bus_device_address_out(bus_device_address_out),
	.output_drive_enable_out(output_drive_enable_out),
	.output_idle_state_select_out(output_idle_state_select_out),
	.fallback_osc_freq_select_out(fallback_osc_freq_select_out),
	.equalizer_gain_out(equalizer_gain_out), .equalizer_on_out(equalizer_on_out),
	.spread_spectrum_setting_out(spread_spectrum_setting_out),
	.spread_slow_mod_out(spread_slow_mod_out), .fallback_clock_on_out(fallback_clock_on_out));
`default_nettype wire

// *** verif/dcrb_host_model.sv ***
// dcrb_host_model: serial bus master that reads and writes the config bank
// assumes: data line has a pull-up; bus clock stands high between frames, 64 ns period
`timescale 1ns/1ps
`default_nettype none
module dcrb_host_model (
	output var logic scl_out, // bus clock
	output var logic sda_oe_out, // pull data low
	input wire logic sda_in // data line level
);
	// --------
	// bus phases
	// --------
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	task automatic reset_clocks(input int n);
		repeat (n) begin
			#32 scl_out = 1'b0;
			#32 scl_out = 1'b1;
		end
	endtask
	task automatic bit_io(input logic b, output logic s);
		sda_oe_out = !b;
		#16 scl_out = 1'b1;
		#16 s = sda_in;
		#16 scl_out = 1'b0;
		#16;
	endtask
	task automatic start();
		#0.7 sda_oe_out = 1'b0;
		#16 scl_out = 1'b1;
		#16 sda_oe_out = 1'b1;
		#16 scl_out = 1'b0;
		#16;
	endtask
	task automatic stop();
		scl_out = 1'b0;
		#16 sda_oe_out = 1'b1;
		#16 scl_out = 1'b1;
		#16 sda_oe_out = 1'b0;
		#16;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(a, ack);
	endtask
	task automatic write_seq(input logic [6:0] dev, input logic [7:0] idx, input int n,
		input logic [31:0] d, output logic ok);
		logic [7:0] q;
		logic a;
		start();
		byte_io({dev, 1'b0}, 1'b1, q, a);
		ok = !a;
		byte_io(idx, 1'b1, q, a);
		ok &= !a;
		for (int k = 0; k < n; k++) begin
			byte_io(d[8*k +: 8], 1'b1, q, a);
			ok &= !a;
		end
		stop();
	endtask
	task automatic read_seq(input logic [6:0] dev, input logic [7:0] idx, input int n,
		output logic [31:0] d, output logic ok);
		logic [7:0] q;
		logic a;
		d = '0;
		start();
		byte_io({dev, 1'b0}, 1'b1, q, a);
		ok = !a;
		byte_io(idx, 1'b1, q, a);
		ok &= !a;
		start();
		byte_io({dev, 1'b1}, 1'b1, q, a);
		ok &= !a;
		for (int k = 0; k < n; k++) begin
			byte_io(8'hff, k == n - 1, q, a); // ack each byte, nack the last
			d[8*k +: 8] = q;
		end
		stop();
	endtask
endmodule // dcrb_host_model
`default_nettype wire

// *** verif/dcrb_tb_top.sv ***
// dcrb_tb_top: self-checking bench for the config bank
// assumes: host model drives the bus; pins driven on falling clock_in
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end
module dcrb_tb_top;
	logic clock_in, rst_n_in, scl_rst_n_in, stream_lost_in, pin_low_freq_in, pin_lane_order_in;
	logic pin_out_en_in, pin_idle_sel_in, pin_swing_in;
	logic [1:0] pin_mode_in, mode;
	logic [2:0] pin_spread_in, osc, gain, spread;
	logic [6:0] strap, cur_addr, addr;
	logic low, lane, sleep, en, idle, swing, eq_on, slow, fb;
	wire logic scl, host_oe, dut_oe, sda;
	int errors, samples_checked;
	assign sda = ~(host_oe | dut_oe); // pull-up when released
	dcrb_top i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .scl_in(scl),
		.scl_rst_n_in(scl_rst_n_in), .sda_in(sda), .sda_oe_out(dut_oe), .bus_address_strap_in(strap),
		.pin_low_freq_in(pin_low_freq_in), .pin_lane_order_in(pin_lane_order_in),
		.pin_mode_in(pin_mode_in), .pin_out_en_in(pin_out_en_in), .pin_idle_sel_in(pin_idle_sel_in),
		.pin_swing_in(pin_swing_in), .pin_spread_in(pin_spread_in), .stream_lost_in(stream_lost_in),
		.low_freq_range_select_out(low), .lane_bit_order_select_out(lane), .link_mode_out(mode),
		.sleep_out(sleep), .bus_device_address_out(addr), .output_drive_enable_out(en),
		.output_idle_state_select_out(idle), .swing_level_select_out(swing),
		.fallback_osc_freq_select_out(osc), .equalizer_gain_out(gain), .equalizer_on_out(eq_on),
		.spread_spectrum_setting_out(spread), .spread_slow_mod_out(slow),
		.fallback_clock_on_out(fb));
	dcrb_host_model i_host (.scl_out(scl), .sda_oe_out(host_oe), .sda_in(sda));
	// --------
	// helpers
	// --------
	task automatic settle();
		repeat (100) @(negedge clock_in);
	endtask
	task automatic wr(input logic [7:0] idx, input int n, input logic [31:0] d);
		logic ok;
		i_host.write_seq(cur_addr, idx, n, d, ok);
		`CHK("write ack", ok, 1'b1)
		settle();
	endtask
	task automatic rd(input logic [7:0] idx, input int n, output logic [31:0] q);
		logic ok;
		i_host.read_seq(cur_addr, idx, n, q, ok);
		`CHK("read ack", ok, 1'b1)
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// --------
	// scenarios
	// --------
	task automatic t_reset();
		logic [31:0] q;
		rd(8'h00, 4, q);
		`CHK("reset regs", q, 32'h0000_7000)
		`CHK("reset addr", addr, 7'h72)
	endtask
	task automatic t_full();
		logic [31:0] q;
		wr(8'h00, 4, 32'hffff_f3ff);
		cur_addr = 7'h73;
		rd(8'h00, 4, q);
		`CHK("masked regs", q, 32'hf7cf_f3cf)
		`CHK("cfg0", {low, lane, mode, sleep}, 5'h1f)
		`CHK("addr", addr, 7'h73)
		`CHK("cfg2", {en, idle, swing, osc}, 6'h3f)
		`CHK("cfg3", {gain, eq_on, spread, slow}, 8'hff)
	endtask
	task automatic t_pins();
		wr(8'h00, 1, 32'h0);
		@(negedge clock_in);
		{pin_low_freq_in, pin_lane_order_in, pin_mode_in} = 4'b1010;
		{pin_out_en_in, pin_idle_sel_in, pin_swing_in, pin_spread_in} = 6'b101110;
		settle();
		`CHK("pin cfg0", {low, lane, mode, sleep}, 5'b10100)
		`CHK("pin cfg2", {en, idle, swing, spread, slow}, 7'b1011101)
		`CHK("addr kept", addr, 7'h73)
		wr(8'h01, 1, 32'h73);
		cur_addr = 7'h72;
		`CHK("strap addr", addr, 7'h72)
		wr(8'h01, 1, 32'hf4);
		`CHK("reserved addr", addr, 7'h72)
		wr(8'h01, 1, 32'hf6);
		cur_addr = 7'h76;
		`CHK("reg addr", addr, 7'h76)
		@(negedge clock_in);
		{pin_low_freq_in, pin_lane_order_in, pin_mode_in, pin_out_en_in} = 5'h0;
		{pin_idle_sel_in, pin_swing_in, pin_spread_in} = 5'h0;
	endtask
	task automatic t_modes();
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(8'h00, 1, {24'h0, m[0], 3'b000, m, 2'b01});
			`CHK("mode", {low, lane, mode}, {m[0], 1'b0, m})
		end
		wr(8'h03, 1, 32'h15);
		`CHK("low range", {eq_on, gain, spread, slow}, 8'b10001011)
		wr(8'h03, 1, 32'h04);
		`CHK("low range slow", {eq_on, spread, slow}, 5'b01000)
	endtask
	task automatic t_fallback();
		wr(8'h02, 2, 32'he5c2);
		`CHK("eq off", {eq_on, gain}, 4'h0)
		@(negedge clock_in);
		stream_lost_in = 1'b1;
		settle();
		`CHK("fallback on", fb, 1'b1)
		wr(8'h02, 1, 32'hc1);
		`CHK("osc reserved", fb, 1'b0)
		wr(8'h02, 1, 32'h42);
		`CHK("drive off", fb, 1'b0)
		@(negedge clock_in);
		stream_lost_in = 1'b0;
	endtask
	task automatic t_refuse();
		logic ok;
		logic [31:0] q;
		i_host.write_seq(7'h75, 8'h00, 1, 32'h0, ok);
		`CHK("foreign nack", ok, 1'b0)
		i_host.write_seq(cur_addr, 8'h03, 2, 32'haa5d, ok);
		rd(8'h00, 1, q);
		`CHK("foreign ignored", q, 32'h8d)
		rd(8'h03, 2, q);
		`CHK("past end", q, 32'h0055)
	endtask
	// --------
	// run
	// --------
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	initial begin
		repeat (100000) @(posedge clock_in);
		errors++;
		finish_test();
	end
	initial begin
		errors = 0;
		samples_checked = 0;
		{rst_n_in, scl_rst_n_in, stream_lost_in, pin_low_freq_in, pin_lane_order_in} = 5'h8;
		{pin_mode_in, pin_out_en_in, pin_idle_sel_in, pin_swing_in, pin_spread_in} = 8'h0;
		strap = 7'h72;
		cur_addr = 7'h72;
		#1 scl_rst_n_in = 1'b0;
		i_host.reset_clocks(4);
		scl_rst_n_in = 1'b1;
		repeat (4) @(negedge clock_in);
		rst_n_in = 1'b1;
		i_host.stop();
		settle();
		t_reset();
		t_full();
		t_pins();
		t_modes();
		t_fallback();
		t_refuse();
		finish_test();
	end
endmodule // dcrb_tb_top
`default_nettype wire
